// [rtl/css_channel_status_sequencer.sv]
// Purpose: Busy response, halt, polling interrupts and resets of a channel control unit
// Assumes: Microprogram sequencer drives the ctl strobes on clk
// Notes:
// Notes on behaviour
// (R1) Short busy only: no chain, last write, ends given, gate on, new start.
// (R2) Erase gate held 60 us after ending, or after index for track writes.
// (R3) Write end without chaining sets internal status-in latch, line stays low.
// (R4) Error bit 7 held reset while operational-in low and status latch set.
// (R5) Steering on compare with select-out low; select-out then raises disconnect-busy.
// (R6) Disconnect-busy sets deferred unit end: error bit 3, bus bits 1,3.
// (R7) Select-out and address-out drop clear steering, status-in and bit 7.
// (R8) Error bit 3 after write leads to a unit-end polling interrupt.
// (R9) Halt releases channel at once; operation ends then polls with status.
// (R10) Channel drops select-out then raises address-out to halt.
// (R11) Halt address-out sets bit 7, degates operational-in, forces command-out.
// (R12) Microprogram drops operational-in, which clears bit 7 and forced command.
// (R13) Halt with no command in progress is ignored.
// (R14) Command-out answering status-in stacks status for a later poll.
// (R15) Non-chained seek arms poll enable; attention then polls device end.
// (R16) Drive inoperable with gate up after write polls unit end and check.
// (R17) Chained seek on multiplexer arms poll-arm latch; attention ignores suppress.
// (R18) Suppress-out withholds every poll except the poll-arm attention.
// (R19) Drive becoming ready polls with device end.
// (R20) Operational-out low, suppress low: general reset, microstore address zero.
// (R21) Suppress high, operational-out low, op-in up: selective reset, status bit 7 set.
// (R22) Microstore error stops program, blocks bit 7, cleared by selective reset.
// (R23) All channel tags pass a synchroniser before use.
module css_channel_status_sequencer #(
	parameter int ERASE_CYC = css_pkg::ERASE_HOLD_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Channel tags
	input wire css_pkg::css_tags_out_t tags_out,
	input wire logic addr_compare,
	output css_pkg::css_tags_in_t tags_in,
	output css_pkg::css_bus_t bus_in,
	// Microprogram controls
	input wire logic ctl_chaining,
	input wire logic ctl_last_write,
	input wire logic ctl_track_write,
	input wire logic ctl_ends_given,
	input wire logic ctl_write_gate,
	input wire logic ctl_opin_set,
	input wire logic ctl_opin_drop,
	input wire logic ctl_cmd_active,
	input wire logic ctl_op_done,
	input wire logic ctl_sts_raise,
	input wire logic ctl_seek_nochain,
	input wire logic ctl_seek_chain_mpx,
	input wire logic ctl_poll_ack,
	input wire logic [7:0] ctl_status,
	// Drive events
	input wire logic drv_index,
	input wire logic drv_attention,
	input wire logic drv_ready,
	input wire logic drv_inoperable,
	input wire logic ustore_error,
	// Microprogram view
	output logic [7:0] error_flag_register,
	output logic [7:0] status_flag_register,
	output logic forced_cmd_out,
	output logic [css_pkg::UADDR_W-1:0] ustore_addr_q,
	output logic ustore_stopped_q,
	output logic erase_gate,
	output logic [7:0] poll_status_q,
	output logic poll_pending_q
);
	logic sel_s;
	logic addr_s;
	logic cmd_s;
	logic sup_s;
	logic opl_s;
	logic opl_q;
	logic sts_latch_q;
	logic steer_q;
	logic err7_q;
	logic err3_q;
	logic poll_en_q;
	logic poll_arm_latch;
	logic stacked_q;
	logic ready_q;
	logic wgate_q;
	logic halt_q;
	logic sel_prev_q;
	logic sts_req_q;
	logic gen_rst;
	logic sel_rst;
	logic disc_busy;
	logic unit_busy_status_line;
	logic short_busy_ok;
	logic erase_start;
	logic erase_busy;
	logic poll_req;
	logic [7:0] poll_d;

	// Tag synchronisers
	css_sync u_sync_sel (.clk(clk), .rst(rst), .d(tags_out.sel_out), .q(sel_s)); // R23
	css_sync u_sync_addr (.clk(clk), .rst(rst), .d(tags_out.addr_out), .q(addr_s)); // R23
	css_sync u_sync_cmd (.clk(clk), .rst(rst), .d(tags_out.cmd_out), .q(cmd_s)); // R23
	css_sync u_sync_sup (.clk(clk), .rst(rst), .d(tags_out.sup_out), .q(sup_s)); // R23
	css_sync u_sync_opl (.clk(clk), .rst(rst), .d(tags_out.opl_out), .q(opl_s)); // R23

	assign gen_rst = !opl_s && !sup_s; // R20
	assign sel_rst = !opl_s && sup_s && opl_q; // R21

	// Erase gate hold
	assign erase_start = (ctl_ends_given && ctl_last_write && !ctl_track_write
		&& !erase_busy && wgate_q && !ctl_write_gate)
		|| (ctl_track_write && wgate_q && drv_index); // R2
	css_erase_timer #(.CYCLES(ERASE_CYC)) u_erase (
		.clk(clk),
		.rst(rst),
		.start(erase_start),
		.clear(gen_rst),
		.busy(erase_busy)
	);

	// Write gate: track writes hold it to index
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wgate_q <= 1'b0;
		else if (gen_rst)
			wgate_q <= 1'b0;
		else if (ctl_write_gate)
			wgate_q <= 1'b1;
		else if (!ctl_track_write || drv_index)
			wgate_q <= 1'b0; // R2
	end

	assign erase_gate = erase_busy || wgate_q;

	assign short_busy_ok = !ctl_chaining && ctl_last_write && ctl_ends_given
		&& erase_gate; // R1

	// Microstore stop and address
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ustore_stopped_q <= 1'b0;
		else if (sel_rst)
			ustore_stopped_q <= 1'b0; // R22
		else if (ustore_error)
			ustore_stopped_q <= 1'b1; // R22
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ustore_addr_q <= css_pkg::UADDR_ZERO;
		else if (gen_rst || sel_rst)
			ustore_addr_q <= css_pkg::UADDR_ZERO; // R20 R21
		else if (!ustore_stopped_q)
			ustore_addr_q <= ustore_addr_q + 1'b1;
	end

	// Operational-in
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			opl_q <= 1'b0;
		else if (gen_rst || sel_rst)
			opl_q <= 1'b0;
		else if (ustore_stopped_q && steer_q && sel_s)
			opl_q <= 1'b1; // R22
		else if (ctl_opin_drop && !ustore_stopped_q)
			opl_q <= 1'b0; // R12
		else if (ctl_opin_set)
			opl_q <= 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sel_prev_q <= 1'b0;
		else
			sel_prev_q <= sel_s;
	end

	// Status-in latch set on write end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sts_latch_q <= 1'b0;
		else if (gen_rst || sel_rst)
			sts_latch_q <= 1'b0;
		else if (ctl_opin_drop && opl_q && ctl_last_write && !ctl_chaining)
			sts_latch_q <= 1'b1; // R3
		else if (!erase_gate)
			sts_latch_q <= 1'b0;
	end

	// Steering latch
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			steer_q <= 1'b0;
		else if (gen_rst || sel_rst)
			steer_q <= 1'b0;
		else if (!sel_s && !addr_s)
			steer_q <= 1'b0; // R7
		else if (!sel_s && addr_s && addr_compare)
			steer_q <= 1'b1; // R5
	end

	// Halt recognised: address-out while op-in up and command active
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			halt_q <= 1'b0;
		else if (gen_rst || sel_rst || !opl_q)
			halt_q <= 1'b0; // R12
		else if (!sel_s && addr_s && addr_compare && ctl_cmd_active)
			halt_q <= 1'b1; // R11 R13
	end

	// Error bit 7
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			err7_q <= 1'b0;
		else if (gen_rst || sel_rst || ustore_stopped_q)
			err7_q <= 1'b0; // R22
		else if (halt_q)
			err7_q <= 1'b1; // R11
		else if (!opl_q && sts_latch_q && steer_q && sel_s && short_busy_ok)
			err7_q <= 1'b1; // R5
		else
			err7_q <= 1'b0; // R4 R7 R12
	end

	assign disc_busy = err7_q;
	assign unit_busy_status_line = disc_busy && steer_q && !opl_q; // R6
	assign forced_cmd_out = disc_busy && opl_q; // R11

	// Deferred unit end and error bit 3
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			err3_q <= 1'b0;
		else if (gen_rst || sel_rst)
			err3_q <= 1'b0;
		else if (unit_busy_status_line)
			err3_q <= 1'b1; // R6
		else if (ctl_op_done && !short_busy_ok)
			err3_q <= 1'b0; // R8
	end

	logic deferred_unit_end_latch;
	assign deferred_unit_end_latch = err3_q;

	always_comb
	begin
		error_flag_register = css_pkg::REG_ZERO;
		error_flag_register[css_pkg::ERR_BUSY_BIT] = err7_q;
		error_flag_register[css_pkg::ERR_UEND_BIT] = deferred_unit_end_latch;
	end

	// Status flags: bit 7 set on selective reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			status_flag_register <= css_pkg::REG_ZERO;
		else if (gen_rst)
			status_flag_register <= css_pkg::REG_ZERO; // R20
		else if (sel_rst)
		begin
			status_flag_register <= css_pkg::REG_ZERO;
			status_flag_register[css_pkg::STAT_RESET_BIT] <= 1'b1; // R21
		end
	end

	// Microprogram status-in and stacking
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sts_req_q <= 1'b0;
		else if (gen_rst || sel_rst || !opl_q)
			sts_req_q <= 1'b0;
		else if (ctl_sts_raise)
			sts_req_q <= 1'b1;
		else if (cmd_s)
			sts_req_q <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stacked_q <= 1'b0;
		else if (gen_rst || sel_rst)
			stacked_q <= 1'b0;
		else if (sts_req_q && cmd_s)
			stacked_q <= 1'b1; // R14
		else if (ctl_poll_ack)
			stacked_q <= 1'b0;
	end

	// Poll sources
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			poll_en_q <= 1'b0;
		else if (gen_rst || sel_rst || ctl_poll_ack)
			poll_en_q <= 1'b0;
		else if (ctl_seek_nochain)
			poll_en_q <= 1'b1; // R15
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			poll_arm_latch <= 1'b0;
		else if (gen_rst || sel_rst || ctl_poll_ack)
			poll_arm_latch <= 1'b0;
		else if (ctl_seek_chain_mpx && !sel_s)
			poll_arm_latch <= 1'b1; // R17
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ready_q <= 1'b0;
		else
			ready_q <= drv_ready;
	end

	// Pending poll status; event set wins over acknowledge
	always_comb
	begin
		poll_d = (ctl_poll_ack) ? css_pkg::REG_ZERO : poll_status_q;
		if (poll_en_q && drv_attention)
			poll_d[css_pkg::ST_DEND] = 1'b1; // R15
		if (poll_arm_latch && drv_attention)
			poll_d[css_pkg::ST_DEND] = 1'b1; // R17
		if (drv_ready && !ready_q)
			poll_d[css_pkg::ST_DEND] = 1'b1; // R19
		if (ctl_op_done && err3_q)
			poll_d[css_pkg::ST_UEND] = 1'b1; // R8
		if (ctl_op_done && halt_q)
			poll_d = poll_d | ctl_status; // R9
		if (drv_inoperable && short_busy_ok)
		begin
			poll_d[css_pkg::ST_UEND] = 1'b1; // R16
			poll_d[css_pkg::ST_UCHECK] = 1'b1; // R16
		end
		if (sts_req_q && cmd_s)
			poll_d = poll_d | ctl_status; // R14
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			poll_status_q <= css_pkg::REG_ZERO;
		else if (gen_rst || sel_rst)
			poll_status_q <= css_pkg::REG_ZERO;
		else
			poll_status_q <= poll_d;
	end

	assign poll_req = (poll_status_q != css_pkg::REG_ZERO);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			poll_pending_q <= 1'b0;
		else if (gen_rst || sel_rst)
			poll_pending_q <= 1'b0;
		else
			poll_pending_q <= poll_req && !opl_q;
	end

	// Channel-facing tags
	always_comb
	begin
		tags_in.opl_in = opl_q && !(disc_busy && !ustore_stopped_q); // R9 R11
		tags_in.sts_in = unit_busy_status_line || (sts_req_q && opl_q); // R3 R6
		tags_in.req_in = (poll_pending_q && !sup_s)
			|| (poll_arm_latch && drv_attention); // R17 R18
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			bus_in <= '0;
		else if (unit_busy_status_line)
		begin
			bus_in.data <= css_pkg::REG_ZERO;
			bus_in.data[css_pkg::BUS_MOD_BIT] <= 1'b1; // R6
			bus_in.data[css_pkg::BUS_BUSY_BIT] <= 1'b1; // R6
			bus_in.par <= 1'b1;
		end
		else
		begin
			bus_in.data <= ctl_status;
			bus_in.par <= ~^ctl_status;
		end
	end

	// Checks
	unit_end_set_a: assert property (@(posedge clk) disable iff (rst)
		unit_busy_status_line |=> err3_q || gen_rst || sel_rst)
		else $error("Unit end latch not set by busy status"); // R6
	hold_reset_a: assert property (@(posedge clk) disable iff (rst)
		(!opl_q && sts_latch_q && !steer_q && !halt_q) |=> !err7_q || gen_rst)
		else $error("Error bit 7 not held reset"); // R4
	halt_degate_a: assert property (@(posedge clk) disable iff (rst)
		(err7_q && opl_q && !ustore_stopped_q) |-> !tags_in.opl_in && forced_cmd_out)
		else $error("Halt did not degate operational-in"); // R11
	sel_reset_a: assert property (@(posedge clk) disable iff (rst)
		sel_rst |=> status_flag_register[7] && ustore_addr_q == 8'h00)
		else $error("Selective reset result wrong"); // R21
	gen_reset_a: assert property (@(posedge clk) disable iff (rst)
		gen_rst |=> ustore_addr_q == 8'h00 && !opl_q)
		else $error("General reset result wrong"); // R20
	suppress_a: assert property (@(posedge clk) disable iff (rst)
		(sup_s && !(poll_arm_latch && drv_attention)) |-> !tags_in.req_in)
		else $error("Poll not suppressed"); // R18
	stack_a: assert property (@(posedge clk) disable iff (rst)
		(sts_req_q && cmd_s && !gen_rst && !sel_rst) |=> stacked_q)
		else $error("Status not stacked"); // R14
	ustore_block_a: assert property (@(posedge clk) disable iff (rst)
		ustore_stopped_q |=> !err7_q)
		else $error("Bit 7 set during microstore stop"); // R22
	busy_bus_a: assert property (@(posedge clk) disable iff (rst)
		unit_busy_status_line |=> bus_in.data[1] && bus_in.data[3])
		else $error("Busy byte missing"); // R6
endmodule : css_channel_status_sequencer

// [rtl/css_pkg.sv]
// Purpose: Shared types and constants for the channel status sequencer
// Assumes: 25 MHz machine clock
// Notes: Tag and bus-in groups travel as packed structs
package css_pkg;
	localparam int CLK_MHZ = 25;
	localparam int ERASE_HOLD_US = 60;
	localparam int ERASE_HOLD_CYC = ERASE_HOLD_US * CLK_MHZ;
	localparam int ERASE_CNT_W = 11;
	localparam int ERR_BUSY_BIT = 7;
	localparam int ERR_UEND_BIT = 3;
	localparam int STAT_RESET_BIT = 7;
	localparam int BUS_MOD_BIT = 1;
	localparam int BUS_BUSY_BIT = 3;
	localparam int UADDR_W = 8;
	localparam logic [UADDR_W-1:0] UADDR_ZERO = 8'h00;
	localparam logic [7:0] REG_ZERO = 8'h00;
	localparam int ST_ATTN = 0;
	localparam int ST_UCHECK = 1;
	localparam int ST_UEND = 2;
	localparam int ST_DEND = 3;
	localparam int ST_STACK = 4;

	typedef struct packed {
		logic sel_out;
		logic addr_out;
		logic cmd_out;
		logic svc_out;
		logic sup_out;
		logic opl_out;
	} css_tags_out_t;

	typedef struct packed {
		logic opl_in;
		logic sts_in;
		logic req_in;
	} css_tags_in_t;

	typedef struct packed {
		logic [7:0] data;
		logic par;
	} css_bus_t;

	typedef enum logic [1:0] {
		CSS_RST_NONE,
		CSS_RST_GEN,
		CSS_RST_SEL
	} css_rst_kind_t;
endpackage : css_pkg

// [rtl/css_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input asynchronous to clk
// Notes: Output follows once stages two and three agree
module css_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic d,
	output logic q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end
		else
		begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= 1'b0;
		else if (s2_q == s3_q)
			q <= s3_q;
	end
endmodule : css_sync

// [rtl/css_erase_timer.sv]
// Purpose: Erase-gate hold timer
// Assumes: start is a one-cycle pulse
// Notes: busy stays high for CYCLES clocks after start
module css_erase_timer #(
	parameter int CYCLES = css_pkg::ERASE_HOLD_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic clear,
	output logic busy
);
	logic [css_pkg::ERASE_CNT_W-1:0] cnt_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_q <= '0;
		else if (clear)
			cnt_q <= '0;
		else if (start)
			cnt_q <= css_pkg::ERASE_CNT_W'(CYCLES);
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	assign busy = (cnt_q != '0);
endmodule : css_erase_timer

// [sim/css_chan_model.sv]
// Purpose: Behavioural channel that drives the tag lines of the sequencer
// Assumes: Lines change 2 ns after a rising edge and idle low, except operational-out, which idles high
// Notes: Operational-out stays high except while a reset is issued
module css_chan_model (
	// Clock
	input wire logic clk,
	// Channel lines
	input wire css_pkg::css_tags_in_t tags_in,
	output css_pkg::css_tags_out_t tags_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		tags_out = '0;
		tags_out.opl_out = 1'b1;
	end

	task step(input int n);
		repeat (n)
		begin
			@(posedge clk);
			#2;
		end
	endtask : step

	// Address first with select low, then select
	task select_probe;
		step(1);
		tags_out.sel_out = 1'b0;
		tags_out.addr_out = 1'b1;
		step(6);
		tags_out.sel_out = 1'b1;
	endtask : select_probe

	task release_sel_addr;
		step(1);
		tags_out.sel_out = 1'b0;
		tags_out.addr_out = 1'b0;
	endtask : release_sel_addr

	task halt_io;
		step(1);
		tags_out.sel_out = 1'b0;
		step(1);
		tags_out.addr_out = 1'b1;
	endtask : halt_io

	task cmd_answer(input logic on);
		step(1);
		tags_out.cmd_out = on;
	endtask : cmd_answer

	task suppress(input logic on);
		step(1);
		tags_out.sup_out = on;
	endtask : suppress

	// Selective when sel is set, otherwise general
	task reset_kind(input logic sel);
		step(1);
		tags_out.sup_out = sel;
		tags_out.opl_out = 1'b0;
		step(8);
		tags_out.opl_out = 1'b1;
		tags_out.sup_out = 1'b0;
	endtask : reset_kind
endmodule : css_chan_model

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the channel status sequencer
// Assumes: Erase hold shortened to 20 cycles
// Notes: Expected and observed values queue up for a separate checker
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst = 1'b1;
	css_pkg::css_tags_out_t tags_out;
	css_pkg::css_tags_in_t tags_in;
	css_pkg::css_bus_t bus_in;
	logic addr_compare = 0, chaining = 0, last_write = 0, track_write = 0, ends_given = 0;
	logic write_gate = 0, opin_set = 0, opin_drop = 0, cmd_active = 0, op_done = 0;
	logic sts_raise = 0, seek_nochain = 0, seek_chain_mpx = 0, poll_ack = 0, drv_index = 0;
	logic drv_attention = 0, drv_ready = 0, drv_inoperable = 0, ustore_error = 0;
	logic [7:0] ctl_status = 8'h00;
	logic [7:0] err_reg, stat_reg, poll_status, uaddr;
	logic forced, stopped, erase_gate, poll_pending;
	logic [4:0] probe;
	int err_count = 0;
	int check_count = 0;
	int seed;
	logic [8:0] exp_q[$];
	logic [8:0] act_q[$];

	always #20 clk = ~clk;
	assign probe = {err_reg[7], forced, poll_pending, tags_in.sts_in, tags_in.req_in};

	css_channel_status_sequencer #(.ERASE_CYC(20)) uut (.clk(clk), .rst(rst),
		.tags_out(tags_out), .addr_compare(addr_compare), .tags_in(tags_in), .bus_in(bus_in),
		.ctl_chaining(chaining), .ctl_last_write(last_write), .ctl_track_write(track_write),
		.ctl_ends_given(ends_given), .ctl_write_gate(write_gate), .ctl_opin_set(opin_set),
		.ctl_opin_drop(opin_drop), .ctl_cmd_active(cmd_active), .ctl_op_done(op_done),
		.ctl_sts_raise(sts_raise), .ctl_seek_nochain(seek_nochain),
		.ctl_seek_chain_mpx(seek_chain_mpx), .ctl_poll_ack(poll_ack), .ctl_status(ctl_status),
		.drv_index(drv_index), .drv_attention(drv_attention), .drv_ready(drv_ready),
		.drv_inoperable(drv_inoperable), .ustore_error(ustore_error),
		.error_flag_register(err_reg), .status_flag_register(stat_reg),
		.forced_cmd_out(forced), .ustore_addr_q(uaddr), .ustore_stopped_q(stopped),
		.erase_gate(erase_gate), .poll_status_q(poll_status), .poll_pending_q(poll_pending));

	css_chan_model chan (.clk(clk), .tags_in(tags_in), .tags_out(tags_out));

	task tick(input int n);
		repeat (n)
		begin
			@(posedge clk);
			#2;
		end
	endtask : tick

	function automatic logic [8:0] b9(input logic b);
		return {8'h00, b};
	endfunction : b9

	task note(input logic [8:0] e, input logic [8:0] a);
		exp_q.push_back(e);
		act_q.push_back(a);
	endtask : note

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse

	// Bounded wait on one probe bit, then record it
	task automatic check_lvl(input int i, input logic v);
		int n;
		n = 0;
		while (probe[i] !== v && n < 20)
		begin
			tick(1);
			n++;
		end
		note(b9(v), b9(probe[i]));
	endtask : check_lvl

	task compare(input logic [8:0] e, input logic [8:0] a);
		check_count++;
		if (a !== e)
		begin
			err_count++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask : compare

	always @(posedge clk)
	begin
		while (act_q.size() > 0)
			compare(exp_q.pop_front(), act_q.pop_front());
	end

	task busy_try(input logic ch);
		chaining = ch;
		last_write = 1'b1;
		ends_given = 1'b1;
		write_gate = 1'b1;
		pulse(opin_set);
		tick(6);
		pulse(opin_drop);
		tick(2);
		note(9'h000, b9(tags_in.sts_in));
		note(9'h000, b9(err_reg[7]));
		note(9'h001, b9(erase_gate));
		addr_compare = 1'b1;
		chan.select_probe();
		check_lvl(1, ~ch);
		if (!ch)
		begin
			tick(1);
			note(9'h001, b9(err_reg[7]));
			note({8'h0A, 1'b1}, bus_in);
			note(9'h001, b9(err_reg[3]));
		end
		chan.release_sel_addr();
		addr_compare = 1'b0;
		check_lvl(1, 1'b0);
		check_lvl(4, 1'b0);
		chaining = 1'b0;
	endtask : busy_try

	task end_sim;
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	initial
	begin
		#(40 * 20000);
		err_count++;
		end_sim();
	end

	initial
	begin
		seed = $urandom(28);
		tick(1);
		note(9'h000, {1'b0, err_reg});
		tick(1);
		rst = 1'b0;
		tick(6);
		repeat (4)
		begin
			ctl_status = 8'($urandom);
			tick(3);
			note({ctl_status, ~^ctl_status}, bus_in);
		end
		busy_try(1'b1);
		busy_try(1'b0);
		write_gate = 1'b0;
		pulse(op_done);
		check_lvl(2, 1'b1);
		note(9'h001, b9(poll_status[css_pkg::ST_UEND]));
		tick(25);
		note(9'h000, b9(erase_gate));
		pulse(poll_ack);
		for (int c = 0; c < 2; c++)
		begin
			cmd_active = c[0];
			pulse(opin_set);
			tick(6);
			addr_compare = 1'b1;
			chan.halt_io();
			tick(8);
			check_lvl(4, c[0]);
			note(b9(c[0]), b9(forced));
			note(b9(~c[0]), b9(tags_in.opl_in));
			pulse(opin_drop);
			check_lvl(4, 1'b0);
			note(9'h000, b9(forced));
			chan.release_sel_addr();
			addr_compare = 1'b0;
			cmd_active = 1'b0;
			tick(6);
		end
		drv_ready = 1'b1;
		check_lvl(2, 1'b1);
		note(9'h001, b9(poll_status[css_pkg::ST_DEND]));
		check_lvl(0, 1'b1);
		chan.suppress(1'b1);
		tick(6);
		note(9'h000, b9(tags_in.req_in));
		pulse(poll_ack);
		pulse(seek_chain_mpx);
		drv_attention = 1'b1;
		check_lvl(0, 1'b1);
		drv_attention = 1'b0;
		pulse(poll_ack);
		chan.suppress(1'b0);
		pulse(seek_nochain);
		drv_attention = 1'b1;
		check_lvl(2, 1'b1);
		note(9'h001, b9(poll_status[css_pkg::ST_DEND]));
		drv_attention = 1'b0;
		pulse(poll_ack);
		pulse(opin_set);
		ctl_status = 8'h0C;
		pulse(sts_raise);
		check_lvl(1, 1'b1);
		chan.cmd_answer(1'b1);
		check_lvl(1, 1'b0);
		chan.cmd_answer(1'b0);
		pulse(opin_drop);
		check_lvl(2, 1'b1);
		note({8'h0C, 1'b0}, {poll_status, 1'b0});
		pulse(poll_ack);
		pulse(opin_set);
		tick(6);
		chan.reset_kind(1'b1);
		tick(6);
		note(9'h001, b9(stat_reg[css_pkg::STAT_RESET_BIT]));
		chan.reset_kind(1'b0);
		tick(6);
		note(9'h000, {1'b0, stat_reg});
		note(9'h000, {1'b0, err_reg});
		tick(3);
		end_sim();
	end
endmodule : tb_top
